/* hdl/cdf_ctrl.sv */
// How it works
// - Inline enabled in receive: CTE parameters come from CP bit and info octet.
// - Data PDU: header1 present when header0 AND mask equals match and CP set.
// - Advertising PDU with extended header: CTE-info flag decides presence.
// - Any extended flag before the CTE-info flag moves the octet six later.
// - Duration in 8 us units; 0 or 1 means 16 us; bound is selectable.
// - Type 0 AoA, 1 AoD 1 us slots 2 us spacing, 2 AoD 2 us, 3 reserved.
// - Inline disabled: no parsing, length from manual 8 us unit setting.
// - Procedure starts at CRC end or address event plus separate offsets.
// - Found CTE in a received packet raises a one-cycle detected event.
// - Eight antenna lines mapped to pins; only connected ones are taken over.
// - In switching modes connected pins drive pattern, otherwise GPIO owns them.
// - Entry 0 from enable task, entry 1 at guard, later ones each slot.
// - Past buffer end restart at entry 2; entry 0 one spacing after last.
// - Software writes three patterns at least; clear task wipes the buffer.
// - Manual spacing between switches; first switch at offset after trigger.
// - Samples go by DMA from the buffer pointer, limited and counted.
// - IQ word: Q high half, I low half, saturate out of range.
// - Magnitude and phase word with zero top bits.
// - Sample offset counted in 16 MHz ticks.
// - Reference period uses reference spacing, then post spacing.
// - AoD receive inline: slot type picks the post reference spacing.
// - AoA receive inline: switch spacing of 2 or 4 us picks spacing.
//
// Local design decisions: the APB slave port and the address map.
`include "cdf_params.svh"
module cdf_ctrl #(
  parameter int NANT      = 8,
  parameter int NPINS     = 32,
  parameter int PAT_DEPTH = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               tx_enable_task,
  input  wire logic               rx_enable_task,
  input  wire logic               address_event,
  input  wire logic               crc_end_event,
  input  wire logic               pattern_clear_task,
  input  wire logic               pkt_octet_valid,
  input  wire logic [7:0]         pkt_octet,
  input  wire logic signed [15:0] iq_i,
  input  wire logic signed [15:0] iq_q,
  output logic                    cte_detected_event,
  output logic                    dma_req,
  output logic      [31:0]        dma_addr,
  output logic      [31:0]        dma_wdata,
  input  wire logic               dma_ack,
  input  wire logic [NPINS-1:0]   gpio_out,
  input  wire logic [NPINS-1:0]   gpio_oe,
  output logic      [NPINS-1:0]   pin_out,
  output logic      [NPINS-1:0]   pin_oe
);
  localparam int PSW = $clog2(NPINS);
  localparam int PIW = $clog2(PAT_DEPTH);
  localparam logic [15:0] GUARD_TK = 16'(`CDF_GUARD_US * `CDF_BASE_MHZ);
  localparam logic [15:0] REF_TK   = 16'(`CDF_REF_US * `CDF_BASE_MHZ);
  localparam logic [7:0]  CLK_RATE = 8'(`CDF_CLK_MHZ);
  localparam logic [7:0]  BASE     = 8'(`CDF_BASE_MHZ);

  typedef struct packed {
    cdf_pkg::cdf_state_t              st;
    logic [31:0]                      ctrl;
    logic [31:0]                      match;
    logic [31:0]                      ispc;
    logic [31:0]                      tim;
    logic [31:0]                      offs;
    logic [31:0]                      ptr;
    logic [13:0]                      maxc;
    logic [13:0]                      done;
    logic [NANT-1:0][PSW:0]           asel;
    logic [PAT_DEPTH-1:0][NANT-1:0]   pat;
    logic [PIW-1:0]                   wr_p;
    logic [PIW:0]                     p_len;
    logic [PIW-1:0]                   p_idx;
    logic                             rx;
    logic [7:0]                       acc;
    logic [15:0]                      tk;
    logic [15:0]                      sw_next;
    logic [15:0]                      smp_next;
    logic                             sw_on;
    logic                             sw_guard;
    logic                             smp_on;
    logic                             own;
    logic [3:0]                       oc;
    logic [7:0]                       h0;
    logic [3:0]                       info_pos;
    logic                             cte_ok;
    logic [5:0]                       units;
    logic [1:0]                       ctype;
    logic                             det;
    logic [NANT-1:0]                  ant;
    logic                             dreq;
    logic [31:0]                      daddr;
    logic [31:0]                      dwdata;
    logic [31:0]                      rdata;
  } cdf_st_t;

  cdf_st_t s_q;
  cdf_st_t s_d;
  logic [31:0] fmt_word;

  cdf_sample_fmt u_fmt (
    .i_raw     (iq_i),
    .q_raw     (iq_q),
    .mag_phase (s_q.ctrl[`CDF_C_FMT]),
    .word      (fmt_word)
  );

  // Switching modes: AoD transmit or AoA receive
  function automatic logic sw_mode(input logic [1:0] mode, input logic rx);
    sw_mode = (mode == `CDF_MODE_AOD && !rx) || (mode == `CDF_MODE_AOA && rx);
  endfunction

  // Zero spacing would stall the timeline, so it counts as one tick
  function automatic logic [15:0] nz(input logic [7:0] v);
    nz = (v == 8'h00) ? 16'h0001 : {8'h00, v};
  endfunction

  function automatic logic known(input logic [11:0] a);
    known = (a <= `CDF_A_STAT) || ((a & `CDF_A_ANT_MASK) == `CDF_A_ANT);
  endfunction

  logic        tick;
  logic        inl;
  logic        trig;
  logic        wr;
  logic        clr;
  logic [7:0]  sw_sp;
  logic [7:0]  post_sp;
  logic [5:0]  bound;
  logic [5:0]  raw_u;
  logic [15:0] len_tk;
  logic [15:0] sw_end;
  logic [15:0] smp_end;
  logic [15:0] ref_end;
  logic [PIW:0] nxt_idx;

  // Parser, timeline, pattern engine, DMA and register file
  always_comb
  begin
    s_d = s_q;
    s_d.det = 1'b0;
    inl = s_q.ctrl[`CDF_C_INLINE] && s_q.rx;
    {tick, s_d.acc} = (s_q.acc + BASE >= CLK_RATE) ?
                      {1'b1, s_q.acc + BASE - CLK_RATE} : {1'b0, s_q.acc + BASE};
    wr  = psel && penable && pwrite;
    clr = pattern_clear_task || (wr && paddr == `CDF_A_TASK && pwdata[`CDF_TASK_CLR]);
    // Inline uses the packet slot type, manual uses the register
    case (s_q.ctype)
      `CDF_TYPE_AOD1: sw_sp = inl ? `CDF_SPC_2US : s_q.tim[`CDF_T_SWSP];
      `CDF_TYPE_AOD2: sw_sp = inl ? `CDF_SPC_4US : s_q.tim[`CDF_T_SWSP];
      default:        sw_sp = s_q.tim[`CDF_T_SWSP];
    endcase
    post_sp = s_q.tim[`CDF_T_POSTSP];
    if (inl && s_q.ctrl[`CDF_C_MODE] == `CDF_MODE_AOD)
    begin
      if (s_q.ctype == `CDF_TYPE_AOD1)
        post_sp = s_q.ispc[`CDF_I_1US];
      else if (s_q.ctype == `CDF_TYPE_AOD2)
        post_sp = s_q.ispc[`CDF_I_2US];
    end
    else if (inl && s_q.ctrl[`CDF_C_MODE] == `CDF_MODE_AOA)
    begin
      if (s_q.tim[`CDF_T_SWSP] == `CDF_SPC_2US)
        post_sp = s_q.ispc[`CDF_I_1US];
      else if (s_q.tim[`CDF_T_SWSP] == `CDF_SPC_4US)
        post_sp = s_q.ispc[`CDF_I_2US];
    end
    case (s_q.ctrl[`CDF_C_RANGE])
      2'h0:    bound = `CDF_RANGE0_MAX;
      2'h1:    bound = `CDF_RANGE1_MAX;
      default: bound = `CDF_RANGE2_MAX;
    endcase
    raw_u = (s_q.ctrl[`CDF_C_RANGE] >= 2'h2) ? pkt_octet[`CDF_INFO_TIME6] :
            {1'b0, pkt_octet[`CDF_INFO_TIME5]};
    len_tk  = {3'h0, s_q.units, 7'h00};
    sw_end  = 16'(s_q.offs[`CDF_O_SW]) + len_tk;
    smp_end = 16'(s_q.offs[`CDF_O_SMP]) + len_tk;
    ref_end = 16'(s_q.offs[`CDF_O_SMP]) + GUARD_TK + REF_TK;
    nxt_idx = {1'b0, s_q.p_idx} + 1'b1;
    trig = s_q.ctrl[`CDF_C_TRIG] ? crc_end_event : address_event;
    if (inl && s_q.ctrl[`CDF_C_INLINE])
      trig = crc_end_event;

    // Register writes
    if (wr)
    begin
      case (paddr)
        `CDF_A_CTRL:  s_d.ctrl  = pwdata;
        `CDF_A_MATCH: s_d.match = pwdata;
        `CDF_A_ISPC:  s_d.ispc  = pwdata;
        `CDF_A_TIM:   s_d.tim   = pwdata;
        `CDF_A_OFFS:  s_d.offs  = pwdata;
        `CDF_A_PTR:   s_d.ptr   = pwdata;
        `CDF_A_MAXC:  s_d.maxc  = pwdata[13:0];
        `CDF_A_PAT:
        begin
          s_d.pat[s_q.wr_p] = pwdata[NANT-1:0];
          s_d.wr_p = (s_q.wr_p == PIW'(PAT_DEPTH - 1)) ? PIW'(2) : s_q.wr_p + 1'b1;
          if (s_q.p_len < (PIW+1)'(PAT_DEPTH))
            s_d.p_len = s_q.p_len + 1'b1;
        end
        default:
        begin
          if ((paddr & `CDF_A_ANT_MASK) == `CDF_A_ANT)
            s_d.asel[paddr[4:2]] = {pwdata[31], pwdata[PSW-1:0]};
        end
      endcase
    end
    if (clr)
    begin
      s_d.pat   = '0;
      s_d.wr_p  = '0;
      s_d.p_len = '0;
    end

    // DMA completion; count what memory really took
    if (s_q.dreq && dma_ack)
    begin
      s_d.dreq = 1'b0;
      s_d.done = s_q.done + 1'b1;
    end

    case (s_q.st)
      cdf_pkg::CDF_IDLE, cdf_pkg::CDF_ARMED:
      begin
        // Header octets while armed in inline receive
        if (s_q.st == cdf_pkg::CDF_ARMED && inl && pkt_octet_valid)
        begin
          // Octet count stops at the top so a long header never wraps into a false match
          if (s_q.oc != 4'hF)
            s_d.oc = s_q.oc + 1'b1;
          if (s_q.oc == 4'h0)
            s_d.h0 = pkt_octet;
          if (s_q.ctrl[`CDF_C_INS1])
          begin
            if (s_q.oc == 4'h0)
              s_d.info_pos = ((pkt_octet & s_q.match[`CDF_M_MASK]) == s_q.match[`CDF_M_VAL]
                              && pkt_octet[`CDF_CP_BIT]) ? `CDF_S1_POS : 4'hF;
          end
          else if (s_q.oc == `CDF_EXT_POS)
          begin
            if (pkt_octet[`CDF_EXT_LEN] == 6'h00 ||
                (s_q.h0 & s_q.match[`CDF_M_MASK]) != s_q.match[`CDF_M_VAL])
              s_d.info_pos = 4'hF;
            else
              s_d.info_pos = `CDF_ADV_INFO;
          end
          else if (s_q.oc == `CDF_FLAG_POS && s_q.info_pos != 4'hF)
          begin
            if (!pkt_octet[`CDF_FLAG_CTE])
              s_d.info_pos = 4'hF;
            else if (|pkt_octet[`CDF_FLAG_PRIOR])
              s_d.info_pos = `CDF_ADV_INFO + `CDF_SHIFT_OCT;
            else
              s_d.info_pos = `CDF_ADV_INFO;
          end
          if (s_q.oc == s_q.info_pos && s_q.info_pos != 4'hF && !s_q.cte_ok)
          begin
            s_d.cte_ok = 1'b1;
            s_d.det    = 1'b1;
            s_d.ctype  = pkt_octet[`CDF_INFO_TYPE];
            s_d.units  = (raw_u < `CDF_MIN_UNITS) ? `CDF_MIN_UNITS :
                         (raw_u > bound) ? bound : raw_u;
          end
        end
        if (s_q.st == cdf_pkg::CDF_ARMED && trig)
        begin
          if (!inl)
          begin
            s_d.units = s_q.tim[`CDF_T_LEN];
            s_d.ctype = 2'h0;
          end
          s_d.st       = cdf_pkg::CDF_RUN;
          s_d.tk       = 16'h0000;
          s_d.sw_next  = 16'(s_q.offs[`CDF_O_SW]);
          s_d.sw_guard = 1'b1;
          s_d.sw_on    = sw_mode(s_q.ctrl[`CDF_C_MODE], s_q.rx);
          s_d.smp_next = 16'(s_q.offs[`CDF_O_SMP]) + GUARD_TK;
          s_d.smp_on   = s_q.rx && s_q.ctrl[`CDF_C_MODE] != 2'h0;
          s_d.p_idx    = PIW'(2);
          if (inl && !s_q.cte_ok)
          begin
            s_d.st  = cdf_pkg::CDF_IDLE;
            s_d.own = 1'b0;
          end
        end
      end
      cdf_pkg::CDF_RUN:
      begin
        if (tick)
          s_d.tk = s_q.tk + 1'b1;
        if (tick && s_q.sw_on && s_q.tk == s_q.sw_next)
        begin
          if (s_q.sw_guard)
          begin
            s_d.ant      = s_q.pat[1];
            s_d.sw_guard = 1'b0;
            s_d.sw_next  = s_q.sw_next + GUARD_TK + REF_TK;
          end
          else if (s_q.sw_next >= sw_end)
          begin
            s_d.ant   = s_q.pat[0];
            s_d.sw_on = 1'b0;
          end
          else
          begin
            s_d.ant     = s_q.pat[s_q.p_idx];
            s_d.p_idx   = (nxt_idx >= s_q.p_len) ? PIW'(2) : nxt_idx[PIW-1:0];
            s_d.sw_next = s_q.sw_next + nz(sw_sp);
          end
        end
        if (tick && s_q.smp_on && s_q.tk == s_q.smp_next)
        begin
          if (s_q.smp_next >= smp_end)
            s_d.smp_on = 1'b0;
          else
          begin
            // One word in flight; a sample meeting a busy port is lost
            if (!s_q.dreq && s_q.done < s_q.maxc)
            begin
              s_d.dreq   = 1'b1;
              s_d.daddr  = s_q.ptr + {16'h0000, s_q.done, 2'b00};
              s_d.dwdata = fmt_word;
            end
            s_d.smp_next = s_q.smp_next + ((s_q.smp_next < ref_end) ?
                           nz(s_q.tim[`CDF_T_REFSP]) : nz(post_sp));
          end
        end
        if (!s_q.sw_on && !s_q.smp_on)
        begin
          s_d.st  = cdf_pkg::CDF_IDLE;
          s_d.own = 1'b0;
        end
      end
      default: s_d.st = cdf_pkg::CDF_IDLE;
    endcase

    // Enable task restarts the procedure state, keeps a pending DMA word, and puts entry 0 out
    if (tx_enable_task || rx_enable_task)
    begin
      s_d.st       = cdf_pkg::CDF_ARMED;
      s_d.rx       = rx_enable_task;
      s_d.oc       = 4'h0;
      s_d.info_pos = 4'hF;
      s_d.cte_ok   = 1'b0;
      s_d.sw_on    = 1'b0;
      s_d.smp_on   = 1'b0;
      s_d.done     = 14'h0000;
      s_d.ant      = s_q.pat[0];
      s_d.own      = sw_mode(s_q.ctrl[`CDF_C_MODE], rx_enable_task);
    end

    // Read data caught in the setup phase
    if (psel && !penable)
    begin
      case (paddr)
        `CDF_A_CTRL:  s_d.rdata = s_q.ctrl;
        `CDF_A_MATCH: s_d.rdata = s_q.match;
        `CDF_A_ISPC:  s_d.rdata = s_q.ispc;
        `CDF_A_TIM:   s_d.rdata = s_q.tim;
        `CDF_A_OFFS:  s_d.rdata = s_q.offs;
        `CDF_A_PAT:   s_d.rdata = 32'(s_q.p_len);
        `CDF_A_PTR:   s_d.rdata = s_q.ptr;
        `CDF_A_MAXC:  s_d.rdata = {18'h00000, s_q.maxc};
        `CDF_A_DONE:  s_d.rdata = {18'h00000, s_q.done};
        `CDF_A_STAT:  s_d.rdata = {16'h0000, s_q.cte_ok, s_q.ctype, s_q.units,
                                   s_q.own, s_q.dreq, 2'b00, s_q.st};
        default:
        begin
          s_d.rdata = `CDF_RST_WORD;
          if ((paddr & `CDF_A_ANT_MASK) == `CDF_A_ANT)
            s_d.rdata = {s_q.asel[paddr[4:2]][PSW], {(31-PSW){1'b0}},
                         s_q.asel[paddr[4:2]][PSW-1:0]};
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q    <= '0;
      s_q.st <= cdf_pkg::CDF_IDLE;
    end
    else
      s_q <= s_d;
  end

  // Pin ownership: acquired pins drive the pattern, others follow GPIO
  genvar p;
  generate
    for (p = 0; p < NPINS; p++)
    begin : g_pin
      logic hit;
      logic val;
      always_comb
      begin
        hit = 1'b0;
        val = 1'b0;
        for (int n = 0; n < NANT; n++)
        begin
          if (s_q.own && s_q.asel[n][PSW] && s_q.asel[n][PSW-1:0] == PSW'(p))
          begin
            hit = 1'b1;
            val = s_q.ant[n];
          end
        end
        pin_out[p] = hit ? val : gpio_out[p];
        pin_oe[p]  = hit ? 1'b1 : gpio_oe[p];
      end
    end
  endgenerate

  assign pready             = psel && penable;
  assign pslverr            = psel && penable && !known(paddr);
  assign prdata             = s_q.rdata;
  assign cte_detected_event = s_q.det;
  assign dma_req            = s_q.dreq;
  assign dma_addr           = s_q.daddr;
  assign dma_wdata          = s_q.dwdata;
endmodule

/* include/cdf_params.svh */
`ifndef CDF_PARAMS_SVH
`define CDF_PARAMS_SVH
// Clock and time base
`define CDF_CLK_MHZ     100
`define CDF_BASE_MHZ    16
`define CDF_GUARD_US    4
`define CDF_REF_US      8
`define CDF_UNIT_SHIFT  7
`define CDF_MIN_UNITS   6'h02
`define CDF_SPC_2US     8'h20
`define CDF_SPC_4US     8'h40
// Register byte offsets
`define CDF_A_CTRL      12'h000
`define CDF_A_MATCH     12'h004
`define CDF_A_ISPC      12'h008
`define CDF_A_TIM       12'h00C
`define CDF_A_OFFS      12'h010
`define CDF_A_PAT       12'h014
`define CDF_A_TASK      12'h018
`define CDF_A_PTR       12'h01C
`define CDF_A_MAXC      12'h020
`define CDF_A_DONE      12'h024
`define CDF_A_STAT      12'h028
`define CDF_A_ANT       12'h040
`define CDF_A_ANT_MASK  12'hFE0
`define CDF_RST_WORD    32'h00000000
// Register fields
`define CDF_C_INLINE    0
`define CDF_C_INS1      1
`define CDF_C_MODE      3:2
`define CDF_C_TRIG      4
`define CDF_C_FMT       5
`define CDF_C_RANGE     7:6
`define CDF_M_MASK      7:0
`define CDF_M_VAL       15:8
`define CDF_I_1US       7:0
`define CDF_I_2US       15:8
`define CDF_T_LEN       5:0
`define CDF_T_SWSP      15:8
`define CDF_T_REFSP     23:16
`define CDF_T_POSTSP    31:24
`define CDF_O_SW        12:0
`define CDF_O_SMP       28:16
`define CDF_TASK_CLR    0
// Packet header layout
`define CDF_CP_BIT      5
`define CDF_S1_POS      4'h2
`define CDF_EXT_POS     4'h2
`define CDF_FLAG_POS    4'h3
`define CDF_ADV_INFO    4'h4
`define CDF_SHIFT_OCT   4'h6
`define CDF_EXT_LEN     5:0
`define CDF_FLAG_CTE    2
`define CDF_FLAG_PRIOR  1:0
`define CDF_INFO_TIME5  4:0
`define CDF_INFO_TIME6  5:0
`define CDF_INFO_TYPE   7:6
`define CDF_RANGE0_MAX  6'h14
`define CDF_RANGE1_MAX  6'h1F
`define CDF_RANGE2_MAX  6'h3F
`define CDF_MODE_AOA    2'h1
`define CDF_MODE_AOD    2'h2
`define CDF_TYPE_AOD1   2'h1
`define CDF_TYPE_AOD2   2'h2
// Sample format
`define CDF_SAT_VAL     16'h8000
`define CDF_PI64        16'h00C9
`endif

/* include/cdf_pkg.sv */
package cdf_pkg;
  typedef enum logic [2:0] {
    CDF_IDLE  = 3'b001,
    CDF_ARMED = 3'b010,
    CDF_RUN   = 3'b100
  } cdf_state_t;
endpackage

/* hdl/cdf_sample_fmt.sv */
`include "cdf_params.svh"
module cdf_sample_fmt #(
  parameter int STAGES = 8
) (
  input  wire logic signed [15:0] i_raw,
  input  wire logic signed [15:0] q_raw,
  input  wire logic               mag_phase,
  output logic             [31:0] word
);
  // Out of 12-bit range check on the top sign bits
  function automatic logic fits12(input logic [15:0] v);
    fits12 = (&v[15:11]) | ~(|v[15:11]);
  endfunction

  function automatic logic signed [15:0] clamp12(input logic signed [15:0] v);
    if (fits12(v))
      clamp12 = v;
    else
      clamp12 = v[15] ? -16'sh0800 : 16'sh07FF;
  endfunction

  // Rotation angles scaled by 64
  function automatic logic signed [15:0] atan64(input int k);
    case (k)
      0: atan64 = 16'sh0032;
      1: atan64 = 16'sh001E;
      2: atan64 = 16'sh0010;
      3: atan64 = 16'sh0008;
      4: atan64 = 16'sh0004;
      5: atan64 = 16'sh0002;
      6: atan64 = 16'sh0001;
      default: atan64 = 16'sh0000;
    endcase
  endfunction

  logic signed [15:0] ci;
  logic signed [15:0] cq;
  logic signed [15:0] cx [STAGES+1];
  logic signed [15:0] cy [STAGES+1];
  logic signed [15:0] cz [STAGES+1];

  // Vectoring rotation; its gain is the wanted magnitude scale
  assign ci    = clamp12(i_raw);
  assign cq    = clamp12(q_raw);
  assign cx[0] = ci[15] ? -ci : ci;
  assign cy[0] = ci[15] ? -cq : cq;
  assign cz[0] = ci[15] ? (cq[15] ? -16'(`CDF_PI64) : 16'(`CDF_PI64)) : 16'sh0000;

  genvar k;
  generate
    for (k = 0; k < STAGES; k++)
    begin : g_stage
      assign cx[k+1] = cy[k][15] ? cx[k] - (cy[k] >>> k) : cx[k] + (cy[k] >>> k);
      assign cy[k+1] = cy[k][15] ? cy[k] + (cx[k] >>> k) : cy[k] - (cx[k] >>> k);
      assign cz[k+1] = cy[k][15] ? cz[k] - atan64(k) : cz[k] + atan64(k);
    end
  endgenerate

  // Q high, I low; saturated code marks out of range input
  always_comb
  begin
    if (mag_phase)
      word = {3'h0, cx[STAGES][12:0], {7{cz[STAGES][8]}}, cz[STAGES][8:0]};
    else
      word = {fits12(q_raw) ? q_raw : `CDF_SAT_VAL,
              fits12(i_raw) ? i_raw : `CDF_SAT_VAL};
  end
endmodule

/* verif/cdf_ctrl_sva.sv */
module cdf_ctrl_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pkt_octet_valid,
  input wire logic        cte_detected_event,
  input wire logic        dma_req,
  input wire logic        dma_ack,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] dma_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answers with no wait states and stays quiet outside access
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("no pready in access");
  bus_quiet_a: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("bus answer outside access");
  unmapped_err_a: assert property (psel && penable && paddr == 12'h02C |-> pslverr)
    else $error("no error for unmapped");
  mapped_ok_a: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
    else $error("error for mapped");
  // Word transfer held until taken
  dma_hold_a: assert property (
    dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_wdata))
    else $error("dma request dropped");
  addr_align_a: assert property (dma_req |-> dma_addr[1:0] == 2'h0)
    else $error("dma address unaligned");
  event_pulse_a: assert property (cte_detected_event |=> !cte_detected_event)
    else $error("detect event too long");
  event_cause_a: assert property ($rose(cte_detected_event) |-> $past(pkt_octet_valid))
    else $error("detect without octet");
  cover property (cte_detected_event);
  cover property (dma_req && dma_ack);
  cover property (psel && penable && pslverr);
endmodule
bind cdf_ctrl cdf_ctrl_sva u_cdf_ctrl_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pkt_octet_valid(pkt_octet_valid), .cte_detected_event(cte_detected_event),
  .dma_req(dma_req), .dma_ack(dma_ack), .dma_addr(dma_addr), .dma_wdata(dma_wdata));

/* verif/cdf_dma_ram.sv */
module cdf_dma_ram #(
  parameter int STALL = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        dma_req,
  input  wire logic [31:0] dma_addr,
  input  wire logic [31:0] dma_wdata,
  output logic             dma_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] a_q [4];
  logic [31:0] w_q [4];
  int          n;
  int          wt;
  // Stalls before each accept so the held request is really exercised
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      n <= 0;
      wt <= 0;
      dma_ack <= 1'b0;
    end
    else if (dma_req && dma_ack)
    begin
      if (n < 4)
      begin
        a_q[n] <= dma_addr;
        w_q[n] <= dma_wdata;
      end
      n <= n + 1;
      wt <= 0;
      dma_ack <= 1'b0;
    end
    else if (dma_req)
    begin
      wt <= wt + 1;
      dma_ack <= (wt >= STALL);
    end
endmodule

/* verif/tb_cdf_ctrl.sv */
module tb_cdf_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, ov, errv;
  logic               cte_detected_event, dma_req, dma_ack;
  logic        [4:0]  ev;
  logic        [7:0]  pkt_octet;
  logic        [11:0] paddr;
  logic signed [15:0] iq_i, iq_q;
  logic        [31:0] pwdata, prdata, rdv, dma_addr, dma_wdata, gpio_out, gpio_oe, pin_out, pin_oe;
  int                 n_mismatch, checked, cyc, n_evt, i;
  logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h01C, 12'h020, 12'h02C};
  logic [31:0] rw [8] = '{32'hA6, 32'hC3F0, 32'h2010, 32'h40102002, 32'h5000A, 32'h20000100,
                          32'h3, 32'hFFFF};
  logic [31:0] re [8] = '{32'hA6, 32'hC3F0, 32'h2010, 32'h40102002, 32'h5000A, 32'h20000100,
                          32'h3, 32'h0};
  cdf_ctrl u_cdf_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_enable_task(ev[0]), .rx_enable_task(ev[1]), .address_event(ev[2]),
    .crc_end_event(ev[3]), .pattern_clear_task(ev[4]), .pkt_octet_valid(ov),
    .pkt_octet(pkt_octet), .iq_i(iq_i), .iq_q(iq_q), .cte_detected_event(cte_detected_event),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe));
  cdf_dma_ram u_cdf_dma_ram (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard and detect-event tally
  always @(posedge pclk)
  begin
    cyc++;
    if (cte_detected_event === 1'b1) n_evt++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Setup then access, held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task pulse(input int k);
    @(posedge pclk);
    ev <= 5'h01 << k;
    @(posedge pclk);
    ev <= 5'h00;
    @(negedge pclk);
  endtask
  task octs(input logic [39:0] v, input int n);
    for (int j = 0; j < n; j++)
    begin
      @(posedge pclk);
      {ov, pkt_octet} <= {1'b1, v[8*j+:8]};
      @(posedge pclk);
      ov <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, ov, pkt_octet} = '0;
    {iq_i, iq_q, gpio_out, gpio_oe} = {16'h0800, 16'hFF00, 32'hA5A5A5A5, 32'h0000FF00};
    {n_mismatch, checked, cyc, n_evt} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h028, 0);
    chk("stat", 32'h1, rdv);
    chk("pins", gpio_out, pin_out);
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      apb(1, ra[i], rw[i]);
      apb(0, ra[i], 0);
      chk("reg", re[i], rdv);
      chk("err", {31'h0, ra[i] == 12'h02C}, {31'h0, errv});
    end
    $display("test registers done");
    // Manual AoA receive: pin 3 carries line 0, patterns 1,0,1, three samples allowed
    apb(1, 12'h000, 32'h4);
    apb(1, 12'h040, 32'h80000003);
    foreach (re[j]) if (j < 3) apb(1, 12'h014, {31'h0, j != 1});
    apb(0, 12'h014, 0);
    chk("count", 32'h3, rdv);
    pulse(1);
    chk("own", gpio_out & ~32'h8 | 32'h8, pin_out);
    chk("oe", gpio_oe | 32'h8, pin_oe);
    pulse(2);
    for (i = 0; i < 300 && pin_out[3] !== 1'b0; i++) @(posedge pclk);
    chk("guard", 32'h0, pin_out[3]);
    for (i = 0; i < 2000 && pin_out[3] !== 1'b1; i++) @(posedge pclk);
    chk("slot", 32'h1, pin_out[3]);
    for (i = 0; i < 4000 && pin_oe[3] !== 1'b0; i++) @(posedge pclk);
    chk("release", gpio_oe, pin_oe);
    apb(0, 12'h024, 0);
    chk("done", 32'h3, rdv);
    chk("addr", 32'h20000108, u_cdf_dma_ram.a_q[2]);
    chk("word", 32'hFF008000, u_cdf_dma_ram.w_q[0]);
    pulse(4);
    apb(0, 12'h014, 0);
    chk("cleared", 32'h0, rdv);
    $display("test switching done");
    // Inline data PDU: header1 present only with bit 5 of header0; then an advertising PDU with extended header and CTE-info flag
    apb(1, 12'h000, 32'h7);
    apb(1, 12'h004, 32'h0);
    pulse(1);
    octs(40'h0000020520, 3);
    chk("detect", 32'h1, n_evt);
    pulse(1);
    octs(40'h0000020500, 3);
    chk("nodetect", 32'h1, n_evt);
    apb(1, 12'h000, 32'h5);
    pulse(1);
    octs(40'h0204010500, 5);
    chk("adv", 32'h2, n_evt);
    pulse(3);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h028, 0);
    chk("rstat", 32'h1, rdv);
    chk("roe", gpio_oe, pin_oe);
    $display("test inline done");
    complete_run;
  end
endmodule
